/* pkg/pld_pkg.sv */
// Shared constants and types for the lane datapath block
package pld_pkg;
	// Lane count and per-lane widths
	localparam int LANES      = 4;
	localparam int LANE_W     = 32;   // Widest parallel word per lane
	localparam int NARROW_W   = 16;   // 2-byte word at the first two generations
	localparam int K_W        = 2;    // Control indicator bits per lane
	localparam int EB_AW      = 3;    // Elastic buffer address width
	localparam int EB_DEPTH   = 8;    // Elastic buffer depth in words
	localparam int EB_W       = LANE_W + K_W + 1; // Data, control bits, skip marker

	// Elastic buffer fill marks
	localparam logic [EB_AW:0] EB_MID = 4'h4;
	localparam logic [EB_AW:0] EB_HI  = 4'h6;
	localparam logic [EB_AW:0] EB_LO  = 4'h2;

	// Link generation codes on the shared rate input
	typedef enum logic [1:0] {
		PLD_GEN1 = 2'h0,
		PLD_GEN2 = 2'h1,
		PLD_GEN3 = 2'h2,
		PLD_GEN4 = 2'h3
	} pld_gen_t;

	// Line encoding selected for the transceivers
	localparam logic PLD_ENC_8B10B   = 1'h0;
	localparam logic PLD_ENC_128B130B = 1'h1;

	// Parallel clock rate codes for the external clock mux
	localparam logic [1:0] PLD_PCLK_125 = 2'h0;
	localparam logic [1:0] PLD_PCLK_250 = 2'h1;
	localparam logic [1:0] PLD_PCLK_500 = 2'h2;

	// Register byte offsets
	localparam logic [3:0] PLD_OFS_CTRL   = 4'h0;
	localparam logic [3:0] PLD_OFS_STATUS = 4'h4;
	localparam logic [3:0] PLD_OFS_EVENTS = 4'h8;

	// Control register fields and reset value
	localparam int          PLD_CTRL_EN_BIT = 0;
	localparam logic [31:0] PLD_CTRL_RST    = 32'h0000_0001;

	// Status register fields
	localparam int PLD_ST_GEN_LSB = 0;
	localparam int PLD_ST_ENC_BIT = 2;
	localparam int PLD_ST_PCK_LSB = 4;

	// Event register fields: overflow lanes low, underflow lanes above
	localparam int PLD_EV_OVF_LSB = 0;
	localparam int PLD_EV_UNF_LSB = 8;
	localparam int PLD_EV_ADD_LSB = 16;
	localparam int PLD_EV_DRP_LSB = 24;
endpackage

/* logic/pld_elastic_buf.sv */
// Receive elastic buffer with skip-based clock correction for one lane
`timescale 1ns/1ps
module pld_elastic_buf (
	input  wire logic                      clk_i,        // Core clock
	input  wire logic                      rst_i,        // Synchronous reset, high
	input  wire logic                      wr_valid_i,   // Incoming word valid
	input  wire logic [pld_pkg::EB_W-1:0]  wr_data_i,    // Word with skip marker on top
	output logic      [pld_pkg::EB_W-1:0]  rd_data_o,    // Registered output word
	output logic                           rd_valid_o,   // Output word valid
	output logic                           ovf_o,        // Word lost, buffer full
	output logic                           unf_o,        // Buffer ran dry
	output logic                           skp_add_o,    // Skip word repeated
	output logic                           skp_drop_o    // Skip word discarded
);
	// Complete state of the buffer
	typedef struct packed {
		logic [pld_pkg::EB_DEPTH-1:0][pld_pkg::EB_W-1:0] mem;   // Storage
		logic [pld_pkg::EB_AW-1:0]                        wptr;  // Write pointer
		logic [pld_pkg::EB_AW-1:0]                        rptr;  // Read pointer
		logic [pld_pkg::EB_AW:0]                          level; // Fill level
		logic                                             run;   // Reading started
		logic [pld_pkg::EB_W-1:0]                         rdata; // Output register
		logic                                             rval;  // Output valid
		logic                                             ovf;   // Event pulses
		logic                                             unf;
		logic                                             add;
		logic                                             drp;
	} pld_eb_t;

	pld_eb_t s_reg;   // Current state
	pld_eb_t s_next;  // Next state

	logic [pld_pkg::EB_W-1:0] head;   // Word at read pointer
	logic                     do_wr;  // Write this cycle
	logic                     do_rd;  // Advance read pointer

	////////////////////////////////////////////////////////////////////////
	// Next state: write side drops skips when high, read side repeats when low
	always_comb begin
		s_next = s_reg;
		head   = s_reg.mem[s_reg.rptr];
		s_next.ovf = 1'b0;
		s_next.unf = 1'b0;
		s_next.add = 1'b0;
		s_next.drp = 1'b0;
		do_wr  = 1'b0;
		do_rd  = 1'b0;
		// Write side
		if (wr_valid_i) begin
			if (wr_data_i[pld_pkg::EB_W-1] && s_reg.level >= pld_pkg::EB_HI) begin
				s_next.drp = 1'b1;   // Too full: discard a skip word
			end else if (s_reg.level == 4'h8) begin
				s_next.ovf = 1'b1;   // No room
			end else begin
				do_wr = 1'b1;
			end
		end
		// Read side starts once half full
		if (!s_reg.run) begin
			s_next.run  = (s_reg.level >= pld_pkg::EB_MID);
			s_next.rval = 1'b0;
		end else if (s_reg.level == 4'h0) begin
			s_next.unf  = 1'b1;      // Empty: restart priming
			s_next.run  = 1'b0;
			s_next.rval = 1'b0;
		end else begin
			s_next.rdata = head;     // Every word passes through storage
			s_next.rval  = 1'b1;
			if (head[pld_pkg::EB_W-1] && s_reg.level <= pld_pkg::EB_LO) begin
				s_next.add = 1'b1;   // Too empty: send the skip again
			end else begin
				do_rd = 1'b1;
			end
		end
		// Pointer and level bookkeeping
		if (do_wr) begin
			s_next.mem[s_reg.wptr] = wr_data_i;
			s_next.wptr = s_reg.wptr + 3'h1;
		end
		if (do_rd) begin
			s_next.rptr = s_reg.rptr + 3'h1;
		end
		s_next.level = s_reg.level + {3'h0, do_wr} - {3'h0, do_rd};
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state
	assign rd_data_o  = s_reg.rdata;
	assign rd_valid_o = s_reg.rval;
	assign ovf_o      = s_reg.ovf;
	assign unf_o      = s_reg.unf;
	assign skp_add_o  = s_reg.add;
	assign skp_drop_o = s_reg.drp;
endmodule

/* logic/pld_lane_datapath.sv */
// Lane datapath top: rate control, transmit shaping, receive elastic buffers, registers
`timescale 1ns/1ps
module pld_lane_datapath (
	input  wire logic                                  clk_i,          // Core clock, 250 MHz
	input  wire logic                                  rst_i,          // Synchronous reset, high
	input  wire logic                                  sys_reset_n_i,  // Fundamental reset pin
	// Wishbone slave
	input  wire logic                                  wb_cyc_i,
	input  wire logic                                  wb_stb_i,
	input  wire logic                                  wb_we_i,
	input  wire logic [3:0]                            wb_adr_i,
	input  wire logic [3:0]                            wb_sel_i,
	input  wire logic [31:0]                           wb_dat_i,
	output logic      [31:0]                           wb_dat_o,
	output logic                                       wb_ack_o,
	// Controller side, shared rate
	input  wire logic [1:0]                            pipe_rate_i,
	input  wire logic [pld_pkg::LANES*pld_pkg::LANE_W-1:0] pipe_txdata_i,
	input  wire logic [pld_pkg::LANES*pld_pkg::K_W-1:0]    pipe_txdatak_i,
	output logic      [pld_pkg::LANES*pld_pkg::LANE_W-1:0] pipe_rxdata_o,
	output logic      [pld_pkg::LANES*pld_pkg::K_W-1:0]    pipe_rxdatak_o,
	output logic      [pld_pkg::LANES-1:0]             pipe_rxvalid_o,
	output logic                                       pipe_rx_beacon_o,
	output logic      [1:0]                            pclk_rate_o,
	output logic                                       phy_reset_o,
	// Transceiver side
	output logic      [pld_pkg::LANES*pld_pkg::LANE_W-1:0] gt_txdata_o,
	output logic      [pld_pkg::LANES*pld_pkg::K_W-1:0]    gt_txctrl_o,
	output logic                                       gt_enc_mode_o,
	input  wire logic [pld_pkg::LANES*pld_pkg::LANE_W-1:0] gt_rxdata_i,
	input  wire logic [pld_pkg::LANES*pld_pkg::K_W-1:0]    gt_rxctrl_i,
	input  wire logic [pld_pkg::LANES-1:0]             gt_rxvalid_i,
	input  wire logic [pld_pkg::LANES-1:0]             gt_rxskp_i
);
	localparam int L  = pld_pkg::LANES;
	localparam int W  = pld_pkg::LANE_W;
	localparam int KW = pld_pkg::K_W;

	// Complete state of the top level
	typedef struct packed {
		logic [2:0]        rsync;   // Reset pin synchroniser
		logic              rst_n;   // Filtered reset pin level
		logic [31:0]       ctrl;    // Control register
		logic [31:0]       events;  // Sticky buffer events
		logic              ack;     // Bus acknowledge
		logic [31:0]       rdat;    // Bus read data
		logic [1:0]        gen;     // Current generation
		logic [1:0]        pck;     // Parallel clock code
		logic              enc;     // Encoding selection
		logic [L*W-1:0]    txd;     // Shaped transmit data
		logic [L*KW-1:0]   txk;     // Shaped transmit control
		logic [L*W-1:0]    rxd;     // Receive data to controller
		logic [L*KW-1:0]   rxk;     // Receive control to controller
		logic [L-1:0]      rxv;     // Receive valid to controller
	} pld_top_t;

	pld_top_t s_reg;   // Current state
	pld_top_t s_next;  // Next state

	logic                    phy_rst;       // Whole-PHY reset
	logic [L*pld_pkg::EB_W-1:0] eb_rd;      // Buffer outputs, packed per lane
	logic [L-1:0]            eb_val;        // Buffer output valid
	logic [L-1:0]            eb_ovf;        // Overflow pulses
	logic [L-1:0]            eb_unf;        // Underflow pulses
	logic [L-1:0]            eb_add;        // Skip insert pulses
	logic [L-1:0]            eb_drp;        // Skip drop pulses
	logic [31:0]             ev_set;        // Event bits set this cycle
	logic [31:0]             ev_clr;        // Event bits cleared by software
	logic [31:0]             wmask;         // Byte lane write mask
	logic                    bus_req;       // New bus request

	// Reset of everything but the pin synchroniser
	assign phy_rst = rst_i | ~s_reg.rst_n;

	////////////////////////////////////////////////////////////////////////
	// One elastic buffer per lane, every lane identical
	genvar g;
	generate
		for (g = 0; g < L; g++) begin : g_lane
			pld_elastic_buf u_eb (
				.clk_i      (clk_i),
				.rst_i      (phy_rst),
				.wr_valid_i (gt_rxvalid_i[g]),
				.wr_data_i  ({gt_rxskp_i[g], gt_rxctrl_i[g*KW +: KW], gt_rxdata_i[g*W +: W]}),
				.rd_data_o  (eb_rd[g*pld_pkg::EB_W +: pld_pkg::EB_W]),
				.rd_valid_o (eb_val[g]),
				.ovf_o      (eb_ovf[g]),
				.unf_o      (eb_unf[g]),
				.skp_add_o  (eb_add[g]),
				.skp_drop_o (eb_drp[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Event gathering and byte-lane mask
	always_comb begin
		ev_set = 32'h0;
		ev_set[pld_pkg::PLD_EV_OVF_LSB +: L] = eb_ovf;
		ev_set[pld_pkg::PLD_EV_UNF_LSB +: L] = eb_unf;
		ev_set[pld_pkg::PLD_EV_ADD_LSB +: L] = eb_add;
		ev_set[pld_pkg::PLD_EV_DRP_LSB +: L] = eb_drp;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		bus_req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
		ev_clr = 32'h0;
		if (bus_req && wb_we_i && wb_adr_i == pld_pkg::PLD_OFS_EVENTS) begin
			ev_clr = wb_dat_i & wmask;   // Write one to clear
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_next = s_reg;
		// Three-stage pin synchroniser, change accepted when the last two stages agree
		s_next.rsync = {s_reg.rsync[1:0], sys_reset_n_i};
		if (s_reg.rsync[1] == s_reg.rsync[2]) begin
			s_next.rst_n = s_reg.rsync[2];
		end
		// Bus slave: one-cycle answer, unmapped reads zero
		s_next.ack = bus_req;
		if (bus_req) begin
			unique case (wb_adr_i)
				pld_pkg::PLD_OFS_CTRL: begin
					s_next.rdat = s_reg.ctrl;
					if (wb_we_i) begin
						s_next.ctrl = (s_reg.ctrl & ~wmask) | (wb_dat_i & wmask);
					end
				end
				pld_pkg::PLD_OFS_STATUS: begin
					s_next.rdat = 32'h0;
					s_next.rdat[pld_pkg::PLD_ST_GEN_LSB +: 2] = s_reg.gen;
					s_next.rdat[pld_pkg::PLD_ST_ENC_BIT]      = s_reg.enc;
					s_next.rdat[pld_pkg::PLD_ST_PCK_LSB +: 2] = s_reg.pck;
				end
				pld_pkg::PLD_OFS_EVENTS: begin
					s_next.rdat = s_reg.events;
				end
				default: begin
					s_next.rdat = 32'h0;
				end
			endcase
		end
		// Sticky events: a new event beats a clear in the same cycle
		s_next.events = (s_reg.events & ~ev_clr) | ev_set;
		// Shared rate input steers every lane at once
		s_next.gen = pipe_rate_i;
		unique case (pld_pkg::pld_gen_t'(s_reg.gen))
			pld_pkg::PLD_GEN1: begin
				s_next.pck = pld_pkg::PLD_PCLK_125;
				s_next.enc = pld_pkg::PLD_ENC_8B10B;
			end
			pld_pkg::PLD_GEN2: begin
				s_next.pck = pld_pkg::PLD_PCLK_250;
				s_next.enc = pld_pkg::PLD_ENC_8B10B;
			end
			pld_pkg::PLD_GEN3: begin
				s_next.pck = pld_pkg::PLD_PCLK_250;
				s_next.enc = pld_pkg::PLD_ENC_128B130B;
			end
			pld_pkg::PLD_GEN4: begin
				s_next.pck = pld_pkg::PLD_PCLK_500;
				s_next.enc = pld_pkg::PLD_ENC_128B130B;
			end
		endcase
		// Per-lane shaping, lane zero in the lowest slice
		for (int i = 0; i < L; i++) begin
			if (s_reg.enc == pld_pkg::PLD_ENC_8B10B) begin
				// Two-byte word; upper bits ignored and zeroed
				s_next.txd[i*W +: W] = {16'h0, pipe_txdata_i[i*W +: pld_pkg::NARROW_W]};
				// Indicator passed as given: zero data, one control
				s_next.txk[i*KW +: KW] = pipe_txdatak_i[i*KW +: KW];
				s_next.rxd[i*W +: W] = {16'h0, eb_rd[i*pld_pkg::EB_W +: pld_pkg::NARROW_W]};
				s_next.rxk[i*KW +: KW] = eb_rd[i*pld_pkg::EB_W + W +: KW];
			end else begin
				// Four-byte word; control indicator unused
				s_next.txd[i*W +: W] = pipe_txdata_i[i*W +: W];
				s_next.txk[i*KW +: KW] = 2'h0;
				s_next.rxd[i*W +: W] = eb_rd[i*pld_pkg::EB_W +: W];
				s_next.rxk[i*KW +: KW] = 2'h0;
			end
			s_next.rxv[i] = eb_val[i];
		end
		// Datapath disabled: no lane data, indicators or valid leave the block; clock code and encoding still do
		if (!s_reg.ctrl[pld_pkg::PLD_CTRL_EN_BIT]) begin
			s_next.txd = '0;
			s_next.txk = '0;
			s_next.rxd = '0;
			s_next.rxk = '0;
			s_next.rxv = '0;
		end
		// Reset pin low: clear everything except the synchroniser; control takes its reset value
		if (!s_reg.rst_n) begin
			s_next        = '0;
			s_next.rsync  = {s_reg.rsync[1:0], sys_reset_n_i};
			s_next.rst_n  = (s_reg.rsync[1] == s_reg.rsync[2]) ? s_reg.rsync[2] : 1'b0;
			s_next.ctrl   = pld_pkg::PLD_CTRL_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg      <= '0;
			s_reg.ctrl <= pld_pkg::PLD_CTRL_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs from the state
	assign wb_ack_o         = s_reg.ack;
	assign wb_dat_o         = s_reg.rdat;
	assign pclk_rate_o      = s_reg.pck;
	assign gt_enc_mode_o    = s_reg.enc;
	assign gt_txdata_o      = s_reg.txd;
	assign gt_txctrl_o      = s_reg.txk;
	assign pipe_rxdata_o    = s_reg.rxd;
	assign pipe_rxdatak_o   = s_reg.rxk;
	assign pipe_rxvalid_o   = s_reg.rxv;
	assign phy_reset_o      = phy_rst;
	// No beacon detection exists, so the indication stays low
	assign pipe_rx_beacon_o = 1'b0;
endmodule

/* tb/pld_lane_datapath_chk.sv */
// Concurrent checks on the lane datapath top ports
`timescale 1ns/1ps
module pld_lane_datapath_chk (
	input wire logic         clk_i,
	input wire logic         rst_i,
	input wire logic         sys_reset_n_i,
	input wire logic         wb_cyc_i,
	input wire logic         wb_stb_i,
	input wire logic         wb_we_i,
	input wire logic [3:0]   wb_adr_i,
	input wire logic [3:0]   wb_sel_i,
	input wire logic [31:0]  wb_dat_i,
	input wire logic         wb_ack_o,
	input wire logic [1:0]   pipe_rate_i,
	input wire logic [127:0] pipe_txdata_i,
	input wire logic [7:0]   pipe_txdatak_i,
	input wire logic [3:0]   pipe_rxvalid_o,
	input wire logic         pipe_rx_beacon_o,
	input wire logic [1:0]   pclk_rate_o,
	input wire logic         phy_reset_o,
	input wire logic [127:0] gt_txdata_o,
	input wire logic [7:0]   gt_txctrl_o,
	input wire logic         gt_enc_mode_o
);
	logic en_q; // Output enable as last written
	// Active lane bits: two bytes at the first two generations
	function automatic logic [127:0] msk(input logic [1:0] r);
		msk = r[1] ? {128{1'b1}} : {4{32'h0000FFFF}};
	endfunction
	// Follow the enable bit written over the bus
	always_ff @(posedge clk_i) begin
		if (phy_reset_o)
			en_q <= 1'b1;
		else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0])
			en_q <= wb_dat_i[0];
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (phy_reset_o);
	a_beacon_off: assert property (
		pipe_rx_beacon_o == 1'b0) else $error("beacon output raised");
	a_enc_follows: assert property (
		$stable(pipe_rate_i)[*4] |-> gt_enc_mode_o == pipe_rate_i[1])
		else $error("encoding mode wrong for generation");
	a_pclk_code: assert property (
		$stable(pipe_rate_i)[*4] |-> pclk_rate_o ==
		((pipe_rate_i == 2'h0) ? 2'h0 : (pipe_rate_i == 2'h3) ? 2'h2 : 2'h1))
		else $error("parallel clock code wrong");
	a_tx_width: assert property (
		$stable(pipe_rate_i)[*4] ##0 (en_q && $past(en_q)) |->
		gt_txdata_o == ($past(pipe_txdata_i) & msk(pipe_rate_i)))
		else $error("transmit lanes wrong");
	a_tx_ctrl: assert property (
		$stable(pipe_rate_i)[*4] ##0 (en_q && $past(en_q)) |->
		gt_txctrl_o == (pipe_rate_i[1] ? 8'h00 : $past(pipe_txdatak_i)))
		else $error("transmit control bits wrong");
	a_pin_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		!sys_reset_n_i [*6] |-> phy_reset_o && !wb_ack_o && pipe_rxvalid_o == 4'h0
		&& gt_txdata_o == 128'h0) else $error("pin reset not applied");
	a_ack_next: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
	a_ack_cause: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o)) else $error("stray ack");
	a_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
endmodule
bind pld_lane_datapath pld_lane_datapath_chk pld_lane_datapath_chk_i (
	.clk_i(clk_i), .rst_i(rst_i), .sys_reset_n_i(sys_reset_n_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .pipe_rate_i(pipe_rate_i),
	.pipe_txdata_i(pipe_txdata_i), .pipe_txdatak_i(pipe_txdatak_i),
	.pipe_rxvalid_o(pipe_rxvalid_o), .pipe_rx_beacon_o(pipe_rx_beacon_o),
	.pclk_rate_o(pclk_rate_o), .phy_reset_o(phy_reset_o), .gt_txdata_o(gt_txdata_o),
	.gt_txctrl_o(gt_txctrl_o), .gt_enc_mode_o(gt_enc_mode_o));

/* tb/pld_mac_model.sv */
// Behavioural link-layer controller driving rate and transmit lanes
`timescale 1ns/1ps
module pld_mac_model (
	input  wire logic         clk_i,       // Core clock
	output logic      [1:0]   pipe_rate_o, // Requested generation
	output logic      [127:0] txdata_o,    // Packed transmit lanes
	output logic      [7:0]   txdatak_o    // Packed control indicators
);
	// No power-state requests at all, so lane zero stays up
	// Rate changes only through send; interface rules kept here
	initial begin
		pipe_rate_o = 2'h0;
		txdata_o = 128'h0;
		txdatak_o = 8'h0;
	end
	// New rate and word just after an edge; indicator one marks control
	task automatic send(input logic [1:0] r, input logic [127:0] d, input logic [7:0] k);
		@(posedge clk_i);
		pipe_rate_o <= r;
		txdata_o <= d;
		txdatak_o <= k;
	endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the lane datapath top
`timescale 1ns/1ps
module testbench;
	localparam logic [127:0] TXD  = 128'hF3E2D1C0_B3A29180_73625140_33221100; // Lane words
	localparam logic [127:0] RXW0 = 128'hBEEF0300_BEEF0200_BEEF0100_BEEF0000; // First rx
	logic         clk_i         = 1'b0;   // Core clock
	logic         rst_i         = 1'b1;   // Synchronous reset
	logic         sys_reset_n_i = 1'b1;   // Fundamental reset pin
	logic         wb_cyc_i      = 1'b0;   // Bus cycle
	logic         wb_stb_i      = 1'b0;   // Bus strobe
	logic         wb_we_i       = 1'b0;   // Bus direction
	logic [3:0]   wb_adr_i      = 4'h0;   // Byte address
	logic [3:0]   wb_sel_i      = 4'h0;   // Byte enables
	logic [31:0]  wb_dat_i      = 32'h0;  // Write data
	logic [127:0] gt_rxdata_i   = 128'h0; // Received lanes
	logic [7:0]   gt_rxctrl_i   = 8'h0;   // Received control bits
	logic [3:0]   gt_rxvalid_i  = 4'h0;   // Received valid
	logic [3:0]   gt_rxskp_i    = 4'h0;   // Skip markers
	logic [31:0]  wb_dat_o;               // Read data
	logic         wb_ack_o;               // Bus ack
	logic [1:0]   pipe_rate_i;            // Rate from controller model
	logic [127:0] pipe_txdata_i;          // Tx lanes from controller model
	logic [7:0]   pipe_txdatak_i;         // Tx indicators from controller model
	logic [127:0] pipe_rxdata_o;          // Rx lanes
	logic [7:0]   pipe_rxdatak_o;         // Rx indicators
	logic [3:0]   pipe_rxvalid_o;         // Rx valid
	logic         pipe_rx_beacon_o;       // Beacon output
	logic [1:0]   pclk_rate_o;            // Parallel clock code
	logic         phy_reset_o;            // Combined reset
	logic [127:0] gt_txdata_o;            // Shaped tx lanes
	logic [7:0]   gt_txctrl_o;            // Shaped tx indicators
	logic         gt_enc_mode_o;          // Encoding select
	int           error_cnt     = 0;      // Mismatches
	int           tests_run     = 0;      // Comparisons
	logic         arm           = 1'b0;   // Capture first rx word
	logic [127:0] rx_word;                // Captured rx lanes
	logic [7:0]   rx_k;                   // Captured rx indicators
	always #2 clk_i = ~clk_i;
	pld_lane_datapath pld_lane_datapath_i (.clk_i(clk_i), .rst_i(rst_i),
		.sys_reset_n_i(sys_reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pipe_rate_i(pipe_rate_i),
		.pipe_txdata_i(pipe_txdata_i), .pipe_txdatak_i(pipe_txdatak_i),
		.pipe_rxdata_o(pipe_rxdata_o), .pipe_rxdatak_o(pipe_rxdatak_o),
		.pipe_rxvalid_o(pipe_rxvalid_o), .pipe_rx_beacon_o(pipe_rx_beacon_o),
		.pclk_rate_o(pclk_rate_o), .phy_reset_o(phy_reset_o), .gt_txdata_o(gt_txdata_o),
		.gt_txctrl_o(gt_txctrl_o), .gt_enc_mode_o(gt_enc_mode_o),
		.gt_rxdata_i(gt_rxdata_i), .gt_rxctrl_i(gt_rxctrl_i),
		.gt_rxvalid_i(gt_rxvalid_i), .gt_rxskp_i(gt_rxskp_i));
	pld_mac_model pld_mac_model_i (.clk_i(clk_i), .pipe_rate_o(pipe_rate_i),
		.txdata_o(pipe_txdata_i), .txdatak_o(pipe_txdatak_i));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// One classic bus cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		// No wait limit of its own: only the watchdog ends a hung cycle
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Feed numbered words on all lanes, then go quiet
	task automatic feed(input int nw);
		for (int i = 0; i < nw; i++) begin
			@(posedge clk_i);
			gt_rxvalid_i <= 4'hF;
			gt_rxctrl_i <= 8'h55;
			gt_rxdata_i <= RXW0 | {4{24'h0, 8'(i)}};
		end
		@(posedge clk_i);
		gt_rxvalid_i <= 4'h0;
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Latch the first valid receive word after arming
	always @(posedge clk_i) begin
		if (arm && pipe_rxvalid_o[0] === 1'b1) begin
			rx_word <= pipe_rxdata_o;
			rx_k <= pipe_rxdatak_o;
			arm <= 1'b0;
		end
	end
	// Whole run is under a thousand cycles; this is a generous ceiling
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [127:0] m;
		logic [1:0]   pck;
		logic [31:0]  rd;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		// Reset values, read-only and unmapped places
		wb(1'b0, pld_pkg::PLD_OFS_CTRL, 32'h0, rd);
		chk(128'(rd), 128'(pld_pkg::PLD_CTRL_RST), "ctrl reset value");
		wb(1'b1, pld_pkg::PLD_OFS_STATUS, 32'hFFFF_FFFF, rd);
		wb(1'b0, pld_pkg::PLD_OFS_STATUS, 32'h0, rd);
		chk(128'(rd), 128'h0, "status after write");
		wb(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
		wb(1'b0, 4'hC, 32'h0, rd);
		chk(128'(rd), 128'h0, "unmapped read");
		// Every generation: encoding, width, clock code, rx path, events
		for (int g = 0; g < 4; g++) begin
			m = (g < 2) ? {4{32'h0000FFFF}} : {128{1'b1}};
			pck = (g == 0) ? pld_pkg::PLD_PCLK_125 :
				(g == 3) ? pld_pkg::PLD_PCLK_500 : pld_pkg::PLD_PCLK_250;
			pld_mac_model_i.send(2'(g), TXD, 8'hE4);
			repeat (4) @(posedge clk_i);
			chk(128'(gt_enc_mode_o), 128'(g >= 2), "encoding mode");
			chk(128'(pclk_rate_o), 128'(pck), "clock code");
			chk(gt_txdata_o, TXD & m, "tx lanes");
			chk(128'(gt_txctrl_o), (g < 2) ? 128'hE4 : 128'h0, "tx indicators");
			wb(1'b0, pld_pkg::PLD_OFS_STATUS, 32'h0, rd);
			chk(128'(rd), 128'({pck, 1'b0, g >= 2, 2'(g)}), "status");
			arm = 1'b1;
			feed(6);
			// Wait for the capture; a word that never comes ends in the watchdog
			while (arm) begin
				@(posedge clk_i);
			end
			chk(rx_word, RXW0 & m, "rx first word");
			chk(128'(rx_k), (g < 2) ? 128'h55 : 128'h0, "rx indicators");
			repeat (12) @(posedge clk_i);
			wb(1'b0, pld_pkg::PLD_OFS_EVENTS, 32'h0, rd);
			chk(128'(rd), 128'h0F00, "underflow events");
			wb(1'b1, pld_pkg::PLD_OFS_EVENTS, 32'h0000_0100, rd);
			wb(1'b0, pld_pkg::PLD_OFS_EVENTS, 32'h0, rd);
			chk(128'(rd), 128'h0E00, "lane zero cleared");
			wb(1'b1, pld_pkg::PLD_OFS_EVENTS, 32'hFFFF_FFFF, rd);
			wb(1'b0, pld_pkg::PLD_OFS_EVENTS, 32'h0, rd);
			chk(128'(rd), 128'h0, "events cleared");
		end
		// Skip words with the buffer running low are sent again on every lane
		gt_rxskp_i <= 4'hF;
		feed(6);
		repeat (12) @(posedge clk_i);
		wb(1'b0, pld_pkg::PLD_OFS_EVENTS, 32'h0, rd);
		chk(128'(rd), 128'(32'hF << pld_pkg::PLD_EV_ADD_LSB), "skip repeated");
		gt_rxskp_i <= 4'h0;
		// Enable off blanks both directions
		wb(1'b1, pld_pkg::PLD_OFS_CTRL, 32'h0, rd);
		repeat (3) @(posedge clk_i);
		chk(gt_txdata_o, 128'h0, "tx blanked");
		feed(6);
		// Look while words would be leaving the buffer if not blanked
		repeat (4) @(posedge clk_i);
		chk(128'(pipe_rxvalid_o), 128'h0, "rx blanked");
		// Fundamental reset pin clears the enable back to its reset value
		sys_reset_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk(128'(phy_reset_o), 128'h1, "pin reset seen");
		sys_reset_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk(128'(phy_reset_o), 128'h0, "pin reset released");
		wb(1'b0, pld_pkg::PLD_OFS_CTRL, 32'h0, rd);
		chk(128'(rd), 128'(pld_pkg::PLD_CTRL_RST), "ctrl after pin");
		chk(128'(pipe_rx_beacon_o), 128'h0, "beacon");
		stop_test();
	end
endmodule
